// ==== rtl/light_readout_pkg.sv ====
// Package with register map, field layout and timing constants for the light sensor read-out
package light_readout_pkg;
	localparam logic [4:0] CMD_ADDR_BITS   = 5'h1F;
	localparam logic [4:0] ADDR_IDENTITY   = 5'h12;
	localparam logic [4:0] ADDR_CH0_LOW    = 5'h14;
	localparam logic [4:0] ADDR_CH0_HIGH   = 5'h15;
	localparam logic [4:0] ADDR_CH1_LOW    = 5'h16;
	localparam logic [4:0] ADDR_CH1_HIGH   = 5'h17;
	localparam logic [4:0] ADDR_TICK_LOW   = 5'h18;
	localparam logic [4:0] ADDR_TICK_HIGH  = 5'h19;
	localparam logic [4:0] ADDR_FAMILY     = 5'h1E;
	localparam int         CMD_FLAG_POS    = 7;
	localparam int         PART_CODE_MSB   = 7;
	localparam int         PART_CODE_LSB   = 4;
	localparam int         REV_CODE_MSB    = 3;
	localparam int         REV_CODE_LSB    = 0;
	localparam int         FAMILY_FLAG_POS = 7;
	localparam logic [7:0] RESULT_RESET    = 8'h00;
	localparam logic [7:0] FAMILY_RESET    = 8'h80;
	localparam logic [15:0] TICK_RESET     = 16'h0000;
	// Tick period and clock period in nanoseconds
	localparam int         TICK_NS         = 10900;
	localparam int         CLK_PERIOD_NS   = 100;
	localparam int         TICK_CYCLES     = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] TICK_LAST       = 7'(TICK_CYCLES - 1);
endpackage

// ==== rtl/tick_timer.sv ====
// Manual integration tick counter with prescaler
`timescale 1ns/1ps
module tick_timer
	import light_readout_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        manualRun,
	input  wire logic        manualStart,
	output logic      [15:0] tickCount
);
	logic [6:0] prescale;
	wire        tickDone = (prescale == TICK_LAST);

	always_ff @(posedge clk) begin
		if (srst || manualStart || !manualRun)
			prescale <= 7'h00;
		else if (tickDone)
			prescale <= 7'h00;
		else
			prescale <= prescale + 7'h01;
	end

	// zero at reset and on start
	always_ff @(posedge clk) begin
		if (srst || manualStart)
			tickCount <= TICK_RESET;
		else if (manualRun && tickDone)
			tickCount <= tickCount + 16'h0001;
	end

	property p_tick_step;
		@(posedge clk) disable iff (srst)
		(manualRun && !manualStart && tickDone) |=> (tickCount == $past(tickCount) + 16'h0001);
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("tick count did not advance");

	property p_tick_start;
		@(posedge clk) disable iff (srst)
		manualStart |=> (tickCount == TICK_RESET) && (prescale == 7'h00);
	endproperty
	a_tick_start: assert property (p_tick_start) else $error("start did not clear tick count");
endmodule

// ==== rtl/light_readout_regs.sv ====
// Read-out register group: identity, channel results with shadow, tick timer, family byte
`timescale 1ns/1ps
// Summary of operation
// - The identity byte at its address is read-only and never changes.
// - Bits 7 to 4 of the identity byte return a fixed part-type code.
// - Bits 3 to 0 of the identity byte return the silicon revision code.
// - Each channel result is 16 bits as low and high bytes, channel zero first.
// - All four result bytes are read-only and read zero after reset.
// - A word read from a low result byte returns both bytes of that channel.
// - Reading a low result byte copies that channel's upper byte into a shadow.
// - The shadow stays fixed while new results arrive before the upper read.
// - A manual integration counts elapsed time in ticks of 10.9 us.
// - The tick count is 16 bits, low byte first, and resets to zero.
// - The family byte is writable and has bit 7 set at reset; bits 6 to 0 are reserved.
// - A byte with its top bit set outside a data phase is a command whose address part sets the pointer.
module light_readout_regs
	import light_readout_pkg::*;
#(
	parameter logic [3:0] PART_TYPE_CODE = 4'h5,  // Arbitrary value
	parameter logic [3:0] SILICON_REV    = 4'h1   // Arbitrary value
)(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        hostWrite,
	input  wire logic [7:0]  hostWriteData,
	input  wire logic        hostDataPhase,
	input  wire logic        hostRead,
	input  wire logic        hostWordRead,
	input  wire logic [15:0] ch0Result,
	input  wire logic [15:0] ch1Result,
	input  wire logic        resultUpdate,
	input  wire logic        manualRun,
	input  wire logic        manualStart,
	output logic      [7:0]  readData,
	output logic      [7:0]  readDataHigh,
	output logic      [4:0]  regPointer,
	output logic      [7:0]  familyFlagByte
);
	logic [15:0] ch0Live;
	logic [15:0] ch1Live;
	logic [7:0]  ch0Shadow;
	logic [7:0]  ch1Shadow;
	logic [15:0] tickCount;

	// Register pointer commands: byte with top bit set outside a data phase
	wire cmdByte  = hostWrite && !hostDataPhase && hostWriteData[CMD_FLAG_POS];
	wire dataByte = hostWrite && hostDataPhase;
	wire readCh0  = hostRead && (regPointer == ADDR_CH0_LOW);
	wire readCh1  = hostRead && (regPointer == ADDR_CH1_LOW);

	// part code on top; revision below
	wire [7:0] identityByte = {PART_TYPE_CODE, SILICON_REV};

	tick_timer u_tick_timer (
		.clk        (clk),
		.srst       (srst),
		.manualRun  (manualRun),
		.manualStart(manualStart),
		.tickCount  (tickCount)
	);

	function automatic logic [7:0] read_mux(input logic [4:0] addr);
		case (addr)
			ADDR_IDENTITY: read_mux = identityByte;
			ADDR_CH0_LOW:  read_mux = ch0Live[7:0];
			ADDR_CH0_HIGH: read_mux = ch0Shadow;
			ADDR_CH1_LOW:  read_mux = ch1Live[7:0];
			ADDR_CH1_HIGH: read_mux = ch1Shadow;
			ADDR_TICK_LOW: read_mux = tickCount[7:0];
			ADDR_TICK_HIGH: read_mux = tickCount[15:8];
			ADDR_FAMILY:   read_mux = familyFlagByte;
			default:       read_mux = 8'h00;
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (srst)
			regPointer <= 5'h00;
		else if (cmdByte)
			regPointer <= hostWriteData[4:0] & CMD_ADDR_BITS;
	end

	// results zero at reset, then follow updates
	always_ff @(posedge clk) begin
		if (srst) begin
			ch0Live <= {RESULT_RESET, RESULT_RESET};
			ch1Live <= {RESULT_RESET, RESULT_RESET};
		end else if (resultUpdate) begin
			ch0Live <= ch0Result;
			ch1Live <= ch1Result;
		end
	end

	// strobe shadow on low read; per channel
	// shadow held until the next low read
	always_ff @(posedge clk) begin
		if (srst) begin
			ch0Shadow <= RESULT_RESET;
			ch1Shadow <= RESULT_RESET;
		end else begin
			if (readCh0)
				ch0Shadow <= ch0Live[15:8];
			if (readCh1)
				ch1Shadow <= ch1Live[15:8];
		end
	end

	// family byte is writable; bit 7 set at reset
	always_ff @(posedge clk) begin
		if (srst)
			familyFlagByte <= FAMILY_RESET;
		else if (dataByte && regPointer == ADDR_FAMILY)
			familyFlagByte <= hostWriteData;
	end

	// byte read path; word read pairs live low with live upper
	always_ff @(posedge clk) begin
		if (srst) begin
			readData     <= 8'h00;
			readDataHigh <= 8'h00;
		end else if (hostRead) begin
			readData     <= read_mux(regPointer);
			readDataHigh <= 8'h00;
			if (hostWordRead && readCh0)
				readDataHigh <= ch0Live[15:8];
			else if (hostWordRead && readCh1)
				readDataHigh <= ch1Live[15:8];
			else if (hostWordRead)
				readDataHigh <= read_mux(regPointer + 5'h01);
		end
	end

	property p_id_fixed;
		@(posedge clk) disable iff (srst)
		(hostRead && regPointer == ADDR_IDENTITY) |=>
			(readData[PART_CODE_MSB:PART_CODE_LSB] == PART_TYPE_CODE) &&
			(readData[REV_CODE_MSB:REV_CODE_LSB] == SILICON_REV);
	endproperty
	a_id_fixed: assert property (p_id_fixed) else $error("identity byte wrong");

	property p_rev_code;
		@(posedge clk) disable iff (srst)
		(hostRead && regPointer == ADDR_IDENTITY) |=> readData[3:0] == SILICON_REV;
	endproperty
	a_rev_code: assert property (p_rev_code) else $error("revision code wrong");

	property p_shadow_capture;
		@(posedge clk) disable iff (srst)
		readCh0 |=> (ch0Shadow == $past(ch0Live[15:8])) && (readData == $past(ch0Live[7:0]));
	endproperty
	a_shadow_capture: assert property (p_shadow_capture) else $error("shadow not captured");

	property p_shadow_hold;
		@(posedge clk) disable iff (srst)
		(!readCh0 && resultUpdate) |=> $stable(ch0Shadow);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved on update");

	property p_shadow_own;
		@(posedge clk) disable iff (srst)
		(readCh0 && !readCh1) |=> $stable(ch1Shadow);
	endproperty
	a_shadow_own: assert property (p_shadow_own) else $error("other shadow disturbed");

	property p_word_read;
		@(posedge clk) disable iff (srst)
		(readCh1 && hostWordRead) |=> ({readDataHigh, readData} == $past(ch1Live));
	endproperty
	a_word_read: assert property (p_word_read) else $error("word read not paired");

	property p_pointer;
		@(posedge clk) disable iff (srst)
		cmdByte |=> regPointer == $past(hostWriteData[4:0]);
	endproperty
	a_pointer: assert property (p_pointer) else $error("pointer not stored");

	property p_reset_zero;
		@(posedge clk)
		srst |=> (ch0Live == 16'h0000) && (ch1Live == 16'h0000) && familyFlagByte[FAMILY_FLAG_POS];
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset values wrong");

	property p_word_read0;
		@(posedge clk) disable iff (srst)
		(readCh0 && hostWordRead) |=> ({readDataHigh, readData} == $past(ch0Live));
	endproperty
	a_word_read0: assert property (p_word_read0) else $error("channel zero word not paired");

	property p_shadow_hold1;
		@(posedge clk) disable iff (srst)
		(!readCh1 && resultUpdate) |=> $stable(ch1Shadow);
	endproperty
	a_shadow_hold1: assert property (p_shadow_hold1) else $error("shadow one moved");

	property p_live_read_only;
		@(posedge clk) disable iff (srst)
		(dataByte && !resultUpdate) |=> $stable(ch0Live) && $stable(ch1Live);
	endproperty
	a_live_read_only: assert property (p_live_read_only) else $error("result written");

	property p_pointer_hold;
		@(posedge clk) disable iff (srst)
		!cmdByte |=> $stable(regPointer);
	endproperty
	a_pointer_hold: assert property (p_pointer_hold) else $error("pointer moved");

	property p_byte_high_zero;
		@(posedge clk) disable iff (srst)
		(hostRead && !hostWordRead) |=> (readDataHigh == 8'h00);
	endproperty
	a_byte_high_zero: assert property (p_byte_high_zero) else $error("upper lane not zero");

	property p_tick_read;
		@(posedge clk) disable iff (srst)
		(hostRead && regPointer == ADDR_TICK_LOW) |=> (readData == $past(tickCount[7:0]));
	endproperty
	a_tick_read: assert property (p_tick_read) else $error("tick low byte wrong");

	property p_family_hold;
		@(posedge clk) disable iff (srst)
		!dataByte |=> $stable(familyFlagByte);
	endproperty
	a_family_hold: assert property (p_family_hold) else $error("family byte moved");
endmodule

// ==== bench/host_model.sv ====
// Host side model: command, data and read byte transfers
`timescale 1ns/1ps
module host_model
	import light_readout_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] readData,
	input  wire logic [7:0] readDataHigh,
	output logic            hostWrite,
	output logic [7:0]      hostWriteData,
	output logic            hostDataPhase,
	output logic            hostRead,
	output logic            hostWordRead
);
	initial begin
		hostWrite = 1'b0;
		hostWriteData = 8'h00;
		hostDataPhase = 1'b0;
		hostRead = 1'b0;
		hostWordRead = 1'b0;
	end
	task automatic send(input logic phase, input logic [7:0] b);
		@(posedge clk);
		hostWrite     <= 1'b1;
		hostDataPhase <= phase;
		hostWriteData <= b;
		@(posedge clk);
		hostWrite     <= 1'b0;
		hostWriteData <= ~b;
	endtask
	task automatic fetch(input logic word, output logic [7:0] lo, output logic [7:0] hi);
		@(posedge clk);
		hostRead     <= 1'b1;
		hostWordRead <= word;
		@(posedge clk);
		hostRead     <= 1'b0;
		hostWordRead <= 1'b0;
		#1;
		lo = readData;
		hi = readDataHigh;
	endtask
endmodule

// ==== bench/testbench.sv ====
// Self-checking testbench for the light sensor read-out registers
`timescale 1ns/1ps
module testbench
	import light_readout_pkg::*;
;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [15:0] ch0Result = 16'h0000;
	logic [15:0] ch1Result = 16'h0000;
	logic        resultUpdate = 1'b0;
	logic        manualRun = 1'b0;
	logic        manualStart = 1'b0;
	logic        hostWrite, hostDataPhase, hostRead, hostWordRead;
	logic [7:0]  hostWriteData, readData, readDataHigh, familyFlagByte, lo, hi;
	logic [4:0]  regPointer;
	int          mismatches = 0;
	int          checksDone = 0;
	// Identity codes handed to the design; values are arbitrary
	localparam logic [3:0] PART_CODE_TB = 4'h5;
	localparam logic [3:0] REV_CODE_TB  = 4'h1;

	always #50 clk = ~clk;

	host_model host (.clk(clk), .readData(readData), .readDataHigh(readDataHigh),
		.hostWrite(hostWrite), .hostWriteData(hostWriteData), .hostDataPhase(hostDataPhase),
		.hostRead(hostRead), .hostWordRead(hostWordRead));

	light_readout_regs #(.PART_TYPE_CODE(PART_CODE_TB), .SILICON_REV(REV_CODE_TB))
		dut (.clk(clk), .srst(srst), .hostWrite(hostWrite),
		.hostWriteData(hostWriteData), .hostDataPhase(hostDataPhase), .hostRead(hostRead),
		.hostWordRead(hostWordRead), .ch0Result(ch0Result), .ch1Result(ch1Result),
		.resultUpdate(resultUpdate), .manualRun(manualRun), .manualStart(manualStart),
		.readData(readData), .readDataHigh(readDataHigh), .regPointer(regPointer),
		.familyFlagByte(familyFlagByte));

	task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checksDone++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic rd_check(input logic [4:0] a, input logic [7:0] exp);
		host.send(1'b0, {1'b1, 2'b00, a});
		host.fetch(1'b0, lo, hi);
		check($sformatf("register %h", a), exp, lo);
		check($sformatf("high lane %h", a), 8'h00, hi);
	endtask

	task automatic update(input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		ch0Result    <= a;
		ch1Result    <= b;
		resultUpdate <= 1'b1;
		@(posedge clk);
		resultUpdate <= 1'b0;
	endtask

	task automatic finishTest();
		$display("Checks %0d, mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		check("family port", FAMILY_RESET, familyFlagByte);
		rd_check(ADDR_IDENTITY, {PART_CODE_TB, REV_CODE_TB});
		for (int a = 8'h14; a <= 8'h19; a++) begin
			rd_check(5'(a), RESULT_RESET);
		end
		rd_check(ADDR_FAMILY, FAMILY_RESET);
		rd_check(5'h13, 8'h00);
		$display("Test reset values done");
		update(16'hA1B2, 16'hC3D4);
		rd_check(ADDR_CH0_LOW, 8'hB2);
		update(16'h5566, 16'h7788);
		update(16'h99AA, 16'hBBCC);
		rd_check(ADDR_CH1_LOW, 8'hCC);
		rd_check(ADDR_CH0_HIGH, 8'hA1);
		rd_check(ADDR_CH1_HIGH, 8'hBB);
		$display("Test shadow done");
		host.send(1'b0, {1'b1, 2'b00, ADDR_CH0_LOW});
		host.send(1'b1, 8'h3C);
		host.fetch(1'b1, lo, hi);
		check("word low", 8'hAA, lo);
		check("word high", 8'h99, hi);
		rd_check(ADDR_CH0_HIGH, 8'h99);
		host.send(1'b0, {1'b1, 2'b00, ADDR_CH1_LOW});
		host.fetch(1'b1, lo, hi);
		check("word one low", 8'hCC, lo);
		check("word one high", 8'hBB, hi);
		check("pointer", {3'b000, ADDR_CH1_LOW}, {3'b000, regPointer});
		$display("Test word read done");
		@(posedge clk);
		manualStart <= 1'b1;
		manualRun   <= 1'b1;
		@(posedge clk);
		manualStart <= 1'b0;
		repeat (TICK_CYCLES * 3 + 50) @(posedge clk);
		manualRun <= 1'b0;
		repeat (TICK_CYCLES) @(posedge clk);
		rd_check(ADDR_TICK_LOW, 8'h03);
		rd_check(ADDR_TICK_HIGH, 8'h00);
		host.send(1'b0, {1'b1, 2'b00, ADDR_TICK_LOW});
		host.fetch(1'b1, lo, hi);
		check("tick word low", 8'h03, lo);
		check("tick word high", 8'h00, hi);
		$display("Test tick timer done");
		finishTest();
	end

	initial begin
		#500000;
		mismatches++;
		finishTest();
	end
endmodule
